// ===== pkg/fcsm_pkg.sv
// Constants for the host-side flash command sequencer.
// Assumes a 25 MHz mclk and a byte-wide flash on the far side.
`default_nettype none
package fcsm_pkg;
   // Flash command codes and data byte values
   localparam logic [7:0] CMD_READ = 8'h00;
   localparam logic [7:0] CMD_IDENT = 8'h90;
   localparam logic [7:0] CMD_ERASE = 8'h20;
   localparam logic [7:0] CMD_EVERIFY = 8'ha0;
   localparam logic [7:0] CMD_PROG = 8'h40;
   localparam logic [7:0] CMD_PVERIFY = 8'hc0;
   localparam logic [7:0] CMD_ABORT = 8'hff;
   localparam logic [7:0] ERASED_BYTE = 8'hff;
   localparam logic [7:0] PREP_BYTE = 8'h00;
   // Timing
   localparam int unsigned CLK_PERIOD_NS = 40;
   localparam int unsigned PROG_PULSE_US = 10;
   localparam int unsigned ERASE_PULSE_MS = 10;
   localparam int unsigned CNT_W = 24;
   localparam logic [CNT_W-1:0] PROG_PULSE_CYC = CNT_W'((PROG_PULSE_US * 1000) / CLK_PERIOD_NS);
   localparam int unsigned ERASE_PULSE_CYC_DEF = (ERASE_PULSE_MS * 1000000) / CLK_PERIOD_NS;
   localparam logic [CNT_W-1:0] WE_CYC = 24'h000003;
   localparam logic [CNT_W-1:0] RD_CYC = 24'h000006;
   localparam logic [4:0] PROG_MAX = 5'h19;
   // User operations
   typedef enum logic [1:0] {OP_READ, OP_IDENT, OP_PROG, OP_ERASE} fcsm_op_e;
endpackage : fcsm_pkg
`default_nettype wire

// ===== design/fcsm_host.sv
// Host controller that drives a byte-wide command-register flash over its pins.
// Assumes the flash pins and data bus are external; dq_i is asynchronous.
`default_nettype none
module fcsm_host
   import fcsm_pkg::*;
#(
   parameter int AW = 17,
   parameter int unsigned ERASE_PULSE_CYC = ERASE_PULSE_CYC_DEF,
   parameter int unsigned ERASE_MAX = 1000
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire fcsm_op_e cmd_op,
   input wire logic [AW-1:0] cmd_addr,
   input wire logic [7:0] cmd_data,
   output logic rsp_valid,
   output logic [7:0] rsp_data,
   output logic rsp_fail,
   output logic [AW-1:0] fl_addr,
   output logic [7:0] fl_dq_o,
   output logic fl_dq_oe,
   input wire logic [7:0] fl_dq_i,
   output logic fl_ce_n,
   output logic fl_oe_n,
   output logic fl_we_n,
   output logic vpp_en
);
   if (AW < 1 || AW > 24) begin : g_chk_aw
      $error("AW out of range");
   end
   if (ERASE_PULSE_CYC < 1 || ERASE_PULSE_CYC >= (1 << CNT_W) || ERASE_MAX < 1
       || ERASE_MAX > 65535) begin : g_chk_er
      $error("erase timing out of range");
   end

   typedef enum logic [4:0] {
      S_INIT_A, S_INIT_B, S_INIT_C, S_IDLE, S_WR, S_RD, S_TMR,
      S_RD_CMD, S_RD_DATA, S_ID_CMD, S_ID_DATA,
      S_P_SETUP, S_P_DATA, S_P_WAIT, S_P_VCMD, S_P_VREAD, S_P_CHECK,
      S_E_SETUP, S_E_GO, S_E_WAIT, S_E_VCMD, S_E_VREAD, S_E_CHECK,
      S_FIN, S_DONE
   } fcsm_state_e;
   localparam logic [AW-1:0] LAST_ADDR = '1;
   localparam logic [15:0] ERASE_LIM = 16'(ERASE_MAX);
   fcsm_state_e state_reg, ret_reg, go_ret;
   logic [CNT_W-1:0] cnt_reg, tlen_reg, go_len;
   logic [AW-1:0] addr_reg, go_a;
   logic [7:0] byte_reg, rd_reg, go_d, dq_s1, dq_s2;
   logic [4:0] pcnt_reg;
   logic [15:0] ecnt_reg;
   logic pre_reg, fail_reg, go_wr, go_rd, go_tm;
   // Two-stage synchroniser on the returned data bus
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         dq_s1 <= 8'h00;
         dq_s2 <= 8'h00;
      end else begin
         dq_s1 <= fl_dq_i;
         dq_s2 <= dq_s1;
      end
   end
   // Each step state launches exactly one bus write, bus read or timer
   always_comb begin
      go_wr = 1'b0;
      go_rd = 1'b0;
      go_tm = 1'b0;
      go_a = addr_reg;
      go_d = CMD_READ;
      go_len = PROG_PULSE_CYC;
      go_ret = S_IDLE;
      unique case (state_reg)
         S_INIT_A: begin go_wr = 1'b1; go_d = CMD_ABORT; go_ret = S_INIT_B; end
         S_INIT_B: begin go_wr = 1'b1; go_d = CMD_ABORT; go_ret = S_INIT_C; end
         S_INIT_C: begin go_wr = 1'b1; go_ret = S_IDLE; end
         S_RD_CMD: begin go_wr = 1'b1; go_ret = S_RD_DATA; end
         S_RD_DATA: begin go_rd = 1'b1; go_ret = S_DONE; end
         S_ID_CMD: begin go_wr = 1'b1; go_d = CMD_IDENT; go_ret = S_ID_DATA; end
         S_ID_DATA: begin go_rd = 1'b1; go_ret = S_FIN; end
         S_P_SETUP: begin go_wr = 1'b1; go_d = CMD_PROG; go_ret = S_P_DATA; end
         S_P_DATA: begin go_wr = 1'b1; go_d = byte_reg; go_ret = S_P_WAIT; end
         S_P_WAIT: begin go_tm = 1'b1; go_ret = S_P_VCMD; end
         S_P_VCMD: begin go_wr = 1'b1; go_d = CMD_PVERIFY; go_ret = S_P_VREAD; end
         S_P_VREAD: begin go_rd = 1'b1; go_ret = S_P_CHECK; end
         S_E_SETUP: begin go_wr = 1'b1; go_d = CMD_ERASE; go_ret = S_E_GO; end
         S_E_GO: begin go_wr = 1'b1; go_d = CMD_ERASE; go_ret = S_E_WAIT; end
         S_E_WAIT: begin
            go_tm = 1'b1;
            go_len = CNT_W'(ERASE_PULSE_CYC);
            go_ret = S_E_VCMD;
         end
         S_E_VCMD: begin go_wr = 1'b1; go_d = CMD_EVERIFY; go_ret = S_E_VREAD; end
         S_E_VREAD: begin go_rd = 1'b1; go_ret = S_E_CHECK; end
         S_FIN: begin go_wr = 1'b1; go_ret = S_DONE; end
         default: go_ret = S_IDLE;
      endcase
   end
   wire prog_match = (rd_reg == byte_reg);
   wire byte_erased = (rd_reg == ERASED_BYTE);
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= S_INIT_A;
         ret_reg <= S_IDLE;
         cnt_reg <= '0;
         tlen_reg <= '0;
         addr_reg <= '0;
         byte_reg <= 8'h00;
         rd_reg <= 8'h00;
         pcnt_reg <= 5'h00;
         ecnt_reg <= 16'h0000;
         pre_reg <= 1'b0;
         fail_reg <= 1'b0;
         rsp_valid <= 1'b0;
         fl_addr <= '0;
         fl_dq_o <= 8'h00;
         fl_dq_oe <= 1'b0;
         fl_ce_n <= 1'b1;
         fl_oe_n <= 1'b1;
         fl_we_n <= 1'b1;
         vpp_en <= 1'b0;
      end else begin
         rsp_valid <= 1'b0;
         if (go_wr || go_rd) begin
            fl_addr <= go_a;
            fl_ce_n <= 1'b0;
            fl_oe_n <= ~go_rd;
            fl_dq_oe <= go_wr;
            if (go_wr) fl_dq_o <= go_d;
            cnt_reg <= '0;
            ret_reg <= go_ret;
            state_reg <= go_wr ? S_WR : S_RD;
            if (state_reg == S_P_DATA) pcnt_reg <= pcnt_reg + 5'h01;
            if (state_reg == S_E_GO) ecnt_reg <= ecnt_reg + 16'h0001;
         end else if (go_tm) begin
            cnt_reg <= '0;
            tlen_reg <= go_len;
            ret_reg <= go_ret;
            state_reg <= S_TMR;
         end else begin
            unique case (state_reg)
               S_WR: begin
                  // Address set a cycle before the strobe falls, data held past its rise
                  cnt_reg <= cnt_reg + 1'b1;
                  if (cnt_reg == '0) fl_we_n <= 1'b0;
                  if (cnt_reg == WE_CYC) fl_we_n <= 1'b1;
                  if (cnt_reg == WE_CYC + 1'b1) begin
                     fl_ce_n <= 1'b1;
                     fl_dq_oe <= 1'b0;
                     state_reg <= ret_reg;
                  end
               end
               S_RD: begin
                  // Read window covers access time plus the synchroniser
                  cnt_reg <= cnt_reg + 1'b1;
                  if (cnt_reg == RD_CYC) begin
                     rd_reg <= dq_s2;
                     fl_ce_n <= 1'b1;
                     fl_oe_n <= 1'b1;
                     state_reg <= ret_reg;
                  end
               end
               S_TMR: begin
                  cnt_reg <= cnt_reg + 1'b1;
                  if (cnt_reg == tlen_reg - 1'b1) state_reg <= ret_reg;
               end
               S_IDLE: if (cmd_valid) begin
                  addr_reg <= cmd_addr;
                  byte_reg <= cmd_data;
                  pcnt_reg <= 5'h00;
                  ecnt_reg <= 16'h0000;
                  fail_reg <= 1'b0;
                  pre_reg <= 1'b0;
                  vpp_en <= (cmd_op != OP_READ);
                  unique case (cmd_op)
                     OP_READ: state_reg <= S_RD_CMD;
                     OP_IDENT: state_reg <= S_ID_CMD;
                     OP_PROG: state_reg <= S_P_SETUP;
                     OP_ERASE: begin
                        pre_reg <= 1'b1;
                        addr_reg <= '0;
                        byte_reg <= PREP_BYTE;
                        state_reg <= S_P_SETUP;
                     end
                  endcase
               end
               S_P_CHECK: begin
                  if (prog_match) begin
                     pcnt_reg <= 5'h00;
                     if (pre_reg && addr_reg != LAST_ADDR) begin
                        addr_reg <= addr_reg + 1'b1;
                        state_reg <= S_P_SETUP;
                     end else if (pre_reg) begin
                        pre_reg <= 1'b0;
                        addr_reg <= '0;
                        state_reg <= S_E_SETUP;
                     end else begin
                        state_reg <= S_FIN;
                     end
                  end else if (pcnt_reg >= PROG_MAX) begin
                     fail_reg <= 1'b1;
                     state_reg <= S_FIN;
                  end else begin
                     state_reg <= S_P_SETUP;
                  end
               end
               S_E_CHECK: begin
                  if (byte_erased) begin
                     if (addr_reg == LAST_ADDR) state_reg <= S_FIN;
                     else begin
                        addr_reg <= addr_reg + 1'b1;
                        state_reg <= S_E_VCMD;
                     end
                  end else if (ecnt_reg >= ERASE_LIM) begin
                     fail_reg <= 1'b1;
                     state_reg <= S_FIN;
                  end else begin
                     state_reg <= S_E_SETUP;
                  end
               end
               S_DONE: begin
                  // Supply dropped only after the read command is back in place
                  rsp_valid <= 1'b1;
                  vpp_en <= 1'b0;
                  state_reg <= S_IDLE;
               end
               default: state_reg <= S_IDLE;
            endcase
         end
      end
   end

   assign cmd_ready = (state_reg == S_IDLE);
   assign rsp_data = rd_reg;
   assign rsp_fail = fail_reg;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   wire in_tmr = (state_reg == S_TMR);

   property p_we_sel; !fl_we_n |-> !fl_ce_n && fl_dq_oe && fl_oe_n; endproperty
   a_we_sel: assert property (p_we_sel) else $error("strobe without select");
   property p_we_width; $fell(fl_we_n) |-> !fl_we_n [*3] ##1 fl_we_n; endproperty
   a_we_width: assert property (p_we_width) else $error("strobe width wrong");
   property p_data_hold; $rose(fl_we_n) |-> fl_dq_oe && $stable(fl_dq_o) && !fl_ce_n; endproperty
   a_data_hold: assert property (p_data_hold) else $error("data not held");
   property p_pulse_lim; pcnt_reg <= PROG_MAX; endproperty
   a_pulse_lim: assert property (p_pulse_lim) else $error("too many pulses");
   property p_prog_tmr; go_tm && state_reg == S_P_WAIT |=> ##249 in_tmr ##1 !in_tmr; endproperty
   a_prog_tmr: assert property (p_prog_tmr) else $error("pulse length wrong");
   property p_ev_start; state_reg == S_E_SETUP && $past(state_reg) == S_P_CHECK
      |-> addr_reg == '0; endproperty
   a_ev_start: assert property (p_ev_start) else $error("verify not from zero");
   property p_end_read; state_reg == S_DONE |-> fl_dq_o == CMD_READ; endproperty
   a_end_read: assert property (p_end_read) else $error("op left device mode");
   property p_prog_hold; state_reg == S_P_CHECK && !prog_match |=> $stable(addr_reg); endproperty
   a_prog_hold: assert property (p_prog_hold) else $error("advanced on mismatch");
   property p_ev_hold; state_reg == S_E_CHECK && !byte_erased |=> $stable(addr_reg); endproperty
   a_ev_hold: assert property (p_ev_hold) else $error("verify address lost");
   property p_ev_cmd; state_reg == S_E_VREAD |-> fl_dq_o == CMD_EVERIFY; endproperty
   a_ev_cmd: assert property (p_ev_cmd) else $error("verify read without A0");
   property p_prep; state_reg == S_P_DATA && pre_reg |=> fl_dq_o == PREP_BYTE; endproperty
   a_prep: assert property (p_prep) else $error("preprogram byte wrong");

   c_read: cover property (state_reg == S_RD_DATA ##[1:20] rsp_valid);
   c_retry: cover property (state_reg == S_P_CHECK && !prog_match && !fail_reg);
   c_reerase: cover property (state_reg == S_E_CHECK && !byte_erased);
   c_fail: cover property (rsp_valid && rsp_fail);
endmodule : fcsm_host
`default_nettype wire

// ===== tb/fcsm_flash_model.sv
// Behavioural byte-wide command-register flash for the sequencer bench.
// Assumes the host drives every pin; no clock, events are strobe edges.
`default_nettype none
module fcsm_flash_model #(
   parameter int AW = 3,
   parameter logic [7:0] MAKER_ID = 8'h3c, // Arbitrary value
   parameter logic [7:0] PART_ID = 8'h7e // Arbitrary value
) (
   input wire logic [AW-1:0] fl_addr,
   input wire logic [7:0] fl_dq_o,
   input wire logic fl_dq_oe,
   output logic [7:0] fl_dq_i,
   input wire logic fl_ce_n,
   input wire logic fl_oe_n,
   input wire logic fl_we_n,
   input wire logic vpp_en
);
   timeunit 1ns;
   timeprecision 1ns;
   typedef enum {M_RD, M_ID, M_ESET, M_ERS, M_EV, M_PSET, M_PRG, M_PV, M_AB1, M_AB2} fcsm_mode_e;
   logic [7:0] mem [2**AW];
   fcsm_mode_e mode = M_RD;
   logic [AW-1:0] lat_a, pa, ea, pa_last;
   logic [7:0] pd, rd_val;
   logic [7:0] q_last = 8'h00;
   logic drv_d = 1'b0;
   // Knobs: pulses a byte needs, bytes cleared per erase pulse, read delay
   int prog_need = 1, estep = 4, rd_dly = 5;
   int pcnt, prog_total, epulses, ev_reads, pre_bad;
   wire sel_rd = !fl_ce_n && !fl_oe_n;
   task automatic write_cmd(input logic [7:0] d);
      if (mode == M_ERS) begin
         epulses++;
         foreach (mem[i]) if (i < epulses * estep) mem[i] = 8'hff;
      end
      if (mode == M_PRG && pcnt >= prog_need) mem[pa] = mem[pa] & pd;
      if (!vpp_en) mode = M_RD;
      else if (mode == M_PSET && d != 8'hff) begin
         pa = lat_a;
         pd = d;
         pcnt = (pa == pa_last) ? pcnt + 1 : 1;
         pa_last = pa;
         prog_total++;
         mode = M_PRG;
      end else if ((mode == M_PSET || mode == M_ESET) && d == 8'hff) mode = M_AB1;
      else if (mode == M_AB1 && d == 8'hff) mode = M_AB2;
      else case (d)
         8'h00: mode = M_RD;
         8'h90: mode = M_ID;
         8'h20: begin
            if (mode == M_ESET) begin
               if (epulses == 0) foreach (mem[i]) pre_bad += (mem[i] !== 8'h00);
               mode = M_ERS;
            end else mode = M_ESET;
         end
         8'ha0: begin
            ea = lat_a;
            mode = M_EV;
         end
         8'h40: mode = M_PSET;
         8'hc0: mode = M_PV;
         default: ;
      endcase
   endtask : write_cmd
   always @(negedge fl_we_n) if (!fl_ce_n) lat_a = fl_addr;
   always @(posedge fl_we_n) if (!fl_ce_n) write_cmd(fl_dq_o);
   always @(negedge vpp_en) mode = M_RD;
   always @(posedge sel_rd) if (mode == M_EV) ev_reads++;
   always_comb
      case (mode)
         M_ID: rd_val = fl_addr[0] ? PART_ID : MAKER_ID;
         M_EV: rd_val = mem[ea];
         M_PV: rd_val = mem[pa];
         default: rd_val = mem[fl_addr];
      endcase
   // Slow answers: data only after rd_dly, floating bus shows inverse
   always @(sel_rd) drv_d <= #(rd_dly) sel_rd;
   always @* if (drv_d && sel_rd) q_last = rd_val;
   assign fl_dq_i = (drv_d && sel_rd) ? rd_val : ~q_last;
endmodule : fcsm_flash_model
`default_nettype wire

// ===== tb/fcsm_host_bench.sv
// Self-checking bench for the flash command sequencer.
// Assumes fcsm_flash_model on the far side; expectations queued per op.
`default_nettype none
module fcsm_host_bench
   import fcsm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] MK = 8'h3c; // Arbitrary value
   localparam logic [7:0] PT = 8'h7e; // Arbitrary value
   logic mclk = 1'b0, rstn = 1'b0, cmd_valid = 1'b0;
   fcsm_op_e cmd_op = OP_READ;
   logic [2:0] cmd_addr = 3'h0, fl_addr, a;
   logic [7:0] cmd_data = 8'h00, rsp_data, fl_dq_o, fl_dq_i, r;
   logic cmd_ready, rsp_valid, rsp_fail, fl_dq_oe, fl_ce_n, fl_oe_n, fl_we_n, vpp_en;
   logic [8:0] exp_q [$];
   logic [8:0] e;
   int fail_count = 0, comparisons = 0, cycles = 0, n;
   integer seed = 32'h19d20b3e;
   fcsm_host #(.AW(3), .ERASE_PULSE_CYC(20), .ERASE_MAX(3)) fcsm_host_inst (.mclk(mclk),
      .rstn(rstn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
      .cmd_addr(cmd_addr), .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
      .rsp_fail(rsp_fail), .fl_addr(fl_addr), .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe),
      .fl_dq_i(fl_dq_i), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n),
      .vpp_en(vpp_en));
   fcsm_flash_model #(.AW(3), .MAKER_ID(MK), .PART_ID(PT)) fcsm_flash_model_inst (
      .fl_addr(fl_addr), .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe), .fl_dq_i(fl_dq_i),
      .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .vpp_en(vpp_en));
   initial forever #20 mclk = ~mclk;
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic finish_test;
      if (fail_count == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : finish_test
   // Request held until taken; returns at the edge after the answer
   task automatic op(input fcsm_op_e o, input logic [2:0] ad, input logic [7:0] d,
                     input logic [7:0] ed, input logic ef);
      exp_q.push_back({ef, ed});
      cmd_op = o;
      cmd_addr = ad;
      cmd_data = d;
      cmd_valid = 1'b1;
      while (cmd_ready !== 1'b1) @(negedge mclk);
      @(negedge mclk);
      cmd_valid = 1'b0;
      check("cmd_ready", cmd_ready, 1'b0);
      while (rsp_valid !== 1'b1) @(negedge mclk);
   endtask : op
   always @(negedge mclk) begin
      if (rsp_valid === 1'b1) begin
         if (exp_q.size() == 0) check("response count", 1, 0);
         else begin
            e = exp_q.pop_front();
            check("rsp_data", rsp_data, e[7:0]);
            check("rsp_fail", rsp_fail, e[8]);
         end
      end
   end
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 40000) begin
         fail_count++;
         finish_test();
      end
   end
   initial begin
      repeat (12) @(negedge mclk);
      rstn = 1'b1;
      for (int i = 0; i < 4; i++) begin
         r = 8'($random(seed));
         a = 3'($random(seed));
         fcsm_flash_model_inst.mem[a] = r;
         fcsm_flash_model_inst.rd_dly = (i % 2) ? 100 : 5;
         op(OP_READ, a, 8'h00, r, 1'b0);
      end
      op(OP_IDENT, 3'h0, 8'h00, MK, 1'b0);
      op(OP_IDENT, 3'h1, 8'h00, PT, 1'b0);
      for (int i = 0; i < 2; i++) begin
         a = 3'($random(seed));
         // Never FF: the model takes FF after the program setup command as an abort, not as data
         r = 8'($random(seed)) & 8'hfe;
         n = i ? 30 : 1 + (($random(seed) & 3));
         fcsm_flash_model_inst.mem[a] = 8'hff;
         fcsm_flash_model_inst.pa_last = ~a;
         fcsm_flash_model_inst.prog_total = 0;
         fcsm_flash_model_inst.prog_need = n;
         op(OP_PROG, a, r, i ? 8'hff : r, 1'(i));
         check("program pulses", fcsm_flash_model_inst.prog_total, i ? 25 : n);
         op(OP_READ, a, 8'h00, i ? 8'hff : r, 1'b0);
      end
      for (int i = 0; i < 2; i++) begin
         fcsm_flash_model_inst.estep = i ? 1 : 4;
         fcsm_flash_model_inst.epulses = 0;
         fcsm_flash_model_inst.ev_reads = 0;
         fcsm_flash_model_inst.pre_bad = 0;
         fcsm_flash_model_inst.prog_need = 1;
         op(OP_ERASE, 3'h0, 8'h00, i ? 8'h00 : 8'hff, 1'(i));
         check("erase pulses", fcsm_flash_model_inst.epulses, i ? 3 : 2);
         check("verify reads", fcsm_flash_model_inst.ev_reads, i ? 6 : 9);
         check("preprogram", fcsm_flash_model_inst.pre_bad, 0);
         if (i == 0) op(OP_READ, 3'h7, 8'h00, 8'hff, 1'b0);
      end
      check("final mode", fcsm_flash_model_inst.mode, 0);
      finish_test();
   end
endmodule : fcsm_host_bench
`default_nettype wire
